/* pkg/dsau_defines.vh */
// Purpose: constants for the data space access unit
// Assumes: 16-bit byte-addressed data space, 50 MHz core clock
// Notes: definitions only
`ifndef DSAU_DEFINES_VH
`define DSAU_DEFINES_VH
`define DSAU_AW 16
`define DSAU_DW 16
`define DSAU_SFR_TOP 16'h07FF
`define DSAU_NEAR_TOP 16'h1FFF
`define DSAU_NEAR_W 13
`define DSAU_PSV_BIT 15
`define DSAU_RAM_WORDS 4096
`define DSAU_RAM_AW 12
`define DSAU_RAM_TOP 16'h27FF
`define DSAU_RAM_BASE 16'h0800
`define DSAU_XY_BOUND 16'h1800
`define DSAU_DMA_BASE 16'h2000
`define DSAU_DMA_AW 10
`define DSAU_STEP_BYTE 16'h0001
`define DSAU_STEP_WORD 16'h0002
`define DSAU_LO_BYTE 7:0
`define DSAU_HI_BYTE 15:8
`define DSAU_SIGN_BIT 7
`define DSAU_SFR_WORDS 1024
`define DSAU_SFR_AW 10
`endif

/* rtl/dsau_ram.v */
// Purpose: byte-laned word memory with registered read data
// Assumes: two write ports, two read ports, synchronous read
// Notes: byte lanes share the word decode
`timescale 1ns/1ps
module dsau_ram #(
    parameter AW = 12,
    parameter WORDS = 4096
) (
    input wire i_clk_sys,
    input wire [AW-1:0] i_waddr,
    input wire [1:0] i_wlane,
    input wire [15:0] i_wdata,
    input wire [AW-1:0] i_waddr_b,
    input wire [1:0] i_wlane_b,
    input wire [15:0] i_wdata_b,
    input wire [AW-1:0] i_raddr_a,
    input wire [AW-1:0] i_raddr_b,
    output reg [15:0] o_rdata_a,
    output reg [15:0] o_rdata_b
);
    reg [7:0] mem_lo [0:WORDS-1];
    reg [7:0] mem_hi [0:WORDS-1];
    always @(posedge i_clk_sys) begin
        // port a is written last, so it wins a same-word clash
        if (i_wlane_b[0]) begin
            mem_lo[i_waddr_b] <= i_wdata_b[7:0];
        end
        if (i_wlane_b[1]) begin
            mem_hi[i_waddr_b] <= i_wdata_b[15:8];
        end
        if (i_wlane[0]) begin
            mem_lo[i_waddr] <= i_wdata[7:0];
        end
        if (i_wlane[1]) begin
            mem_hi[i_waddr] <= i_wdata[15:8];
        end
        o_rdata_a <= {mem_hi[i_raddr_a], mem_lo[i_raddr_a]};
        o_rdata_b <= {mem_hi[i_raddr_b], mem_lo[i_raddr_b]};
    end
endmodule // dsau_ram

/* rtl/dsau_top.v */
// Behaviour
// - post-increment steps one per byte, two per word
// - byte read selects by bit 0, lands low
// - shared word decode, per-lane byte writes
// - odd X word access raises address error trap
// - misaligned read completes, trap in the same cycle
// - misaligned write suppressed, then trap
// - byte load writes whole register, high byte zero-filled or widened
// - sign-extend and unsigned-widen operations provided
// - 0x0000-0x07FF decodes to special registers
// - unused special register addresses read zero
// - 13-bit near address reaches 0x0000-0x1FFF
// - 16-bit direct or pointer reaches everything
// - separate X and Y generators and paths
// - X read bus serves unified and prefetch
// - Y read runs parallel with X read
// - modulo both spaces, bit-reverse X writes only
// - writes use unified space, fixed boundary
// - 16-bit byte-granular effective address
// - dual-port DMA RAM at Y top
// - CPU write wins same-location collision
// - DMA never stalls the CPU
// - unimplemented address reads as zero
// - bit 15 set is program visibility window; nothing is mapped there and X reads return zero
// Purpose: data space access for a 16-bit controller core
// Assumes: address generators present one access per cycle
// Notes: reads return two cycles after the request
`timescale 1ns/1ps
`include "dsau_defines.vh"
module dsau_top (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_x_req,
    input wire i_x_we,
    input wire i_x_byte,
    input wire i_x_near,
    input wire [1:0] i_x_mode,
    input wire [15:0] i_x_source_pointer_reg,
    input wire [15:0] i_x_modulo_start,
    input wire [15:0] i_x_modulo_end,
    input wire [15:0] i_x_wdata,
    input wire [3:0] i_x_wreg_sel,
    input wire [1:0] i_x_widen,
    input wire i_y_req,
    input wire i_y_modulo,
    input wire [15:0] i_y_source_pointer_reg,
    input wire [15:0] i_y_modulo_start,
    input wire [15:0] i_y_modulo_end,
    input wire i_dma_req,
    input wire i_dma_we,
    input wire [`DSAU_DMA_AW-1:0] i_dma_addr,
    input wire [15:0] i_dma_wdata,
    input wire [15:0] i_special_register_rdata,
    input wire i_special_register_hit,
    output reg [15:0] o_x_rdata,
    output reg o_x_rvalid,
    output reg [15:0] o_y_rdata,
    output reg o_y_rvalid,
    output reg [15:0] o_x_next_pointer,
    output reg [15:0] o_y_next_pointer,
    output reg o_addr_trap,
    output reg o_special_register_we,
    output reg [1:0] o_special_register_lane,
    output reg [`DSAU_SFR_AW-1:0] o_special_register_addr,
    output reg [15:0] o_special_register_wdata,
    output reg [15:0] o_wreg_data,
    output reg o_wreg_we,
    output reg [3:0] o_wreg_sel,
    output reg [15:0] o_dma_rdata,
    output reg o_dma_rvalid
);
    // x address generator modes
    localparam MODE_PLAIN = 2'b00;
    localparam MODE_POSTINC = 2'b01;
    localparam MODE_MODULO = 2'b10;
    localparam MODE_BITREV = 2'b11;
    // register-load widen modes
    localparam WIDEN_NONE = 2'b00;
    localparam WIDEN_SIGN = 2'b01;
    localparam WIDEN_ZERO = 2'b10;
    // return pipeline states, one-hot
    localparam ST_IDLE = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] x_ea;
    reg [15:0] y_ea;
    reg [15:0] x_step;
    reg [15:0] next_x_ptr;
    reg [15:0] next_y_ptr;
    reg x_misalign;
    reg [1:0] x_lane;
    reg x_in_ram;
    reg x_in_sfr;
    reg y_in_ram;
    reg [15:0] ram_wdata;
    reg [15:0] dma_mux;
    integer i;

    // pipelined request attributes
    reg p_x_valid;
    reg p_x_byte;
    reg p_x_odd;
    reg p_x_ram;
    reg p_x_sfr;
    reg p_x_load;
    reg [3:0] p_x_wsel;
    reg [1:0] p_x_widen;
    reg p_y_valid;
    reg p_y_ram;
    reg p_dma_valid;
    reg p_dma_dual;
    reg p_trap;

    wire [15:0] ram_a;
    wire [15:0] ram_b;
    wire [15:0] ram_dma;

    // effective address and pointer update, x side
    always @* begin
        x_step = i_x_byte ? `DSAU_STEP_BYTE : `DSAU_STEP_WORD;
        x_ea = i_x_near ? {3'b000, i_x_source_pointer_reg[`DSAU_NEAR_W-1:0]}
                        : i_x_source_pointer_reg;
        case (i_x_mode)
            MODE_POSTINC: begin
                next_x_ptr = i_x_source_pointer_reg + x_step;
            end
            MODE_MODULO: begin
                if (i_x_source_pointer_reg >= i_x_modulo_end) begin
                    next_x_ptr = i_x_modulo_start;
                end else begin
                    next_x_ptr = i_x_source_pointer_reg + x_step;
                end
            end
            MODE_BITREV: begin
                // pointer bits reversed only for x writes; reads keep the pointer
                if (i_x_we) begin
                    for (i = 0; i < 16; i = i + 1) begin
                        next_x_ptr[i] = i_x_source_pointer_reg[15-i];
                    end
                end else begin
                    next_x_ptr = i_x_source_pointer_reg;
                end
            end
            default: begin
                next_x_ptr = i_x_source_pointer_reg;
            end
        endcase
        x_misalign = !i_x_byte && x_ea[0];
        x_lane = i_x_byte ? (x_ea[0] ? 2'b10 : 2'b01) : 2'b11;
        x_in_sfr = (x_ea <= `DSAU_SFR_TOP);
        x_in_ram = !x_ea[`DSAU_PSV_BIT] && (x_ea >= `DSAU_RAM_BASE)
                   && (x_ea <= `DSAU_RAM_TOP);
        ram_wdata = i_x_byte ? {i_x_wdata[`DSAU_LO_BYTE], i_x_wdata[`DSAU_LO_BYTE]}
                             : i_x_wdata;
    end

    // y address generator, reads only
    always @* begin
        y_ea = i_y_source_pointer_reg;
        if (i_y_modulo && (i_y_source_pointer_reg >= i_y_modulo_end)) begin
            next_y_ptr = i_y_modulo_start;
        end else begin
            next_y_ptr = i_y_source_pointer_reg + `DSAU_STEP_WORD;
        end
        y_in_ram = !y_ea[`DSAU_PSV_BIT] && (y_ea >= `DSAU_XY_BOUND)
                   && (y_ea <= `DSAU_RAM_TOP);
    end

    // shared word array; write enable gated before issue
    wire x_ram_we = i_x_req && i_x_we && x_in_ram && !x_misalign;
    wire [15:0] x_off = x_ea - `DSAU_RAM_BASE;
    wire [15:0] y_off = y_ea - `DSAU_RAM_BASE;
    wire [15:0] dma_off = `DSAU_DMA_BASE - `DSAU_RAM_BASE;
    wire [`DSAU_RAM_AW-1:0] x_widx = x_off[`DSAU_RAM_AW:1];
    wire [`DSAU_RAM_AW-1:0] y_widx = y_off[`DSAU_RAM_AW:1];
    wire [`DSAU_RAM_AW-1:0] dma_widx = {dma_off[`DSAU_RAM_AW:`DSAU_DMA_AW+1], i_dma_addr};
    wire dma_we_ok = i_dma_req && i_dma_we && !(x_ram_we && (x_widx == dma_widx));

    dsau_ram #(
        .AW(`DSAU_RAM_AW),
        .WORDS(`DSAU_RAM_WORDS)
    ) u_cpu_ram (
        .i_clk_sys(i_clk_sys),
        .i_waddr(x_widx),
        .i_wlane(x_ram_we ? x_lane : 2'b00),
        .i_wdata(ram_wdata),
        .i_waddr_b(dma_widx),
        .i_wlane_b(dma_we_ok ? 2'b11 : 2'b00),
        .i_wdata_b(i_dma_wdata),
        .i_raddr_a(x_widx),
        .i_raddr_b(y_widx),
        .o_rdata_a(ram_a),
        .o_rdata_b(ram_b)
    );

    // dma port reads a mirror so it never takes a cpu cycle
    dsau_ram #(
        .AW(`DSAU_RAM_AW),
        .WORDS(`DSAU_RAM_WORDS)
    ) u_dma_view (
        .i_clk_sys(i_clk_sys),
        .i_waddr(x_widx),
        .i_wlane(x_ram_we ? x_lane : 2'b00),
        .i_wdata(ram_wdata),
        .i_waddr_b(dma_widx),
        .i_wlane_b(dma_we_ok ? 2'b11 : 2'b00),
        .i_wdata_b(i_dma_wdata),
        .i_raddr_a(dma_widx),
        .i_raddr_b(dma_widx),
        .o_rdata_a(ram_dma),
        .o_rdata_b()
    );

    // return state
    always @* begin
        case (state)
            ST_IDLE: begin
                next_state = (i_x_req || i_y_req) ? ST_BUSY : ST_IDLE;
            end
            ST_BUSY: begin
                next_state = (i_x_req || i_y_req) ? ST_BUSY : ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // x read byte selection and register load shaping
    reg [15:0] x_word;
    reg [15:0] x_val;
    reg [15:0] x_load;
    always @* begin
        x_word = p_x_ram ? ram_a
               : (p_x_sfr && i_special_register_hit) ? i_special_register_rdata
               : 16'h0000;
        if (p_x_byte) begin
            x_val = {8'h00, p_x_odd ? x_word[`DSAU_HI_BYTE] : x_word[`DSAU_LO_BYTE]};
        end else begin
            x_val = x_word;
        end
        // widening shapes only the register load; the read bus stays zero-filled
        case (p_x_widen)
            WIDEN_SIGN: begin
                x_load = {{8{x_val[`DSAU_SIGN_BIT]}}, x_val[`DSAU_LO_BYTE]};
            end
            WIDEN_ZERO: begin
                x_load = {8'h00, x_val[`DSAU_LO_BYTE]};
            end
            default: begin
                x_load = x_val;
            end
        endcase
        dma_mux = ram_dma;
    end

    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            p_x_valid <= 1'b0;
            p_x_byte <= 1'b0;
            p_x_odd <= 1'b0;
            p_x_ram <= 1'b0;
            p_x_sfr <= 1'b0;
            p_x_load <= 1'b0;
            p_x_wsel <= 4'h0;
            p_x_widen <= WIDEN_NONE;
            p_y_valid <= 1'b0;
            p_y_ram <= 1'b0;
            p_dma_valid <= 1'b0;
            p_dma_dual <= 1'b0;
            p_trap <= 1'b0;
            o_x_rdata <= 16'h0000;
            o_x_rvalid <= 1'b0;
            o_y_rdata <= 16'h0000;
            o_y_rvalid <= 1'b0;
            o_x_next_pointer <= 16'h0000;
            o_y_next_pointer <= 16'h0000;
            o_addr_trap <= 1'b0;
            o_special_register_we <= 1'b0;
            o_special_register_lane <= 2'b00;
            o_special_register_addr <= {`DSAU_SFR_AW{1'b0}};
            o_special_register_wdata <= 16'h0000;
            o_wreg_data <= 16'h0000;
            o_wreg_we <= 1'b0;
            o_wreg_sel <= 4'h0;
            o_dma_rdata <= 16'h0000;
            o_dma_rvalid <= 1'b0;
        end else begin
            state <= next_state;
            // stage 1: capture
            p_x_valid <= i_x_req && !i_x_we;
            p_x_byte <= i_x_byte;
            p_x_odd <= x_ea[0];
            p_x_ram <= x_in_ram;
            p_x_sfr <= x_in_sfr;
            p_x_load <= i_x_req && !i_x_we && (i_x_wreg_sel != 4'h0 || i_x_widen != WIDEN_NONE);
            p_x_wsel <= i_x_wreg_sel;
            p_x_widen <= i_x_widen;
            p_y_valid <= i_y_req;
            p_y_ram <= y_in_ram;
            p_dma_valid <= i_dma_req && !i_dma_we;
            p_dma_dual <= 1'b1;
            p_trap <= i_x_req && x_misalign;
            o_x_next_pointer <= i_x_req ? next_x_ptr : i_x_source_pointer_reg;
            o_y_next_pointer <= i_y_req ? next_y_ptr : i_y_source_pointer_reg;
            o_special_register_we <= i_x_req && i_x_we && x_in_sfr && !x_misalign;
            o_special_register_lane <= x_lane;
            o_special_register_addr <= x_ea[`DSAU_SFR_AW:1];
            o_special_register_wdata <= ram_wdata;
            // stage 2: return, trap in the same cycle as completion
            o_x_rdata <= x_val;
            o_x_rvalid <= p_x_valid;
            o_y_rdata <= p_y_ram ? ram_b : 16'h0000;
            o_y_rvalid <= p_y_valid;
            o_addr_trap <= p_trap;
            o_wreg_we <= p_x_load;
            o_wreg_sel <= p_x_wsel;
            // byte load drives the whole word to the register file: no lane mask
            o_wreg_data <= x_load;
            o_dma_rdata <= p_dma_dual ? dma_mux : 16'h0000;
            o_dma_rvalid <= p_dma_valid;
        end
    end
endmodule // dsau_top

/* tb/dsau_props.sv */
// Purpose: port assertions for the data space access unit
// Assumes: reads and traps answer two edges after the taking edge
// Notes: bound into dsau_top
`timescale 1ns/1ps
module dsau_props (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_x_req,
    input wire i_x_we,
    input wire i_x_byte,
    input wire i_x_near,
    input wire [15:0] i_x_source_pointer_reg,
    input wire i_y_req,
    input wire [15:0] i_y_source_pointer_reg,
    input wire i_dma_req,
    input wire i_dma_we,
    input wire [15:0] o_x_rdata,
    input wire o_x_rvalid,
    input wire o_y_rvalid,
    input wire o_addr_trap,
    input wire o_special_register_we,
    input wire [1:0] o_special_register_lane,
    input wire o_dma_rvalid
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire ea0 = i_x_source_pointer_reg[0];
    wire odd_word = i_x_req && !i_x_byte && ea0;
    wire x_rd = i_x_req && !i_x_we;
    wire rd_ok = x_rd && !odd_word;
    // odd word writes must never reach a lane
    wire wr_ok = i_x_req && i_x_we && !odd_word;
    property p_x_lat; rd_ok |-> ##2 o_x_rvalid; endproperty
    a_x_lat: assert property (p_x_lat) else $error("x read unanswered");
    property p_x_cause; o_x_rvalid |-> $past(x_rd, 2); endproperty
    a_x_cause: assert property (p_x_cause) else $error("x data without read");
    property p_xy; rd_ok && i_y_req && !i_y_source_pointer_reg[0] |-> ##2 o_x_rvalid && o_y_rvalid;
    endproperty
    a_xy: assert property (p_xy) else $error("x and y not parallel");
    property p_trap; odd_word |-> ##2 o_addr_trap; endproperty
    a_trap: assert property (p_trap) else $error("odd word access not trapped");
    property p_trap_cause; o_addr_trap |-> $past(odd_word, 2); endproperty
    a_trap_cause: assert property (p_trap_cause) else $error("spurious trap");
    property p_sfr_we; o_special_register_we |-> $past(wr_ok); endproperty
    a_sfr_we: assert property (p_sfr_we) else $error("bad register write");
    property p_lane;
        o_special_register_we && $past(i_x_byte) |->
            o_special_register_lane == ($past(ea0) ? 2'h2 : 2'h1);
    endproperty
    a_lane: assert property (p_lane) else $error("wrong byte lane");
    property p_byte_hi; o_x_rvalid && $past(i_x_byte, 2) |-> o_x_rdata[15:8] == 8'h00; endproperty
    a_byte_hi: assert property (p_byte_hi) else $error("byte read high not zero");
    property p_psv;
        rd_ok && !i_x_near && i_x_source_pointer_reg[15] |-> ##2 o_x_rdata == 16'h0000;
    endproperty
    a_psv: assert property (p_psv) else $error("upper half read not zero");
    property p_dma; i_dma_req && !i_dma_we |-> ##2 o_dma_rvalid; endproperty
    a_dma: assert property (p_dma) else $error("dma read unanswered");
endmodule // dsau_props
bind dsau_top dsau_props dsau_props_inst (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_x_req(i_x_req), .i_x_we(i_x_we), .i_x_byte(i_x_byte), .i_x_near(i_x_near),
    .i_x_source_pointer_reg(i_x_source_pointer_reg), .i_y_req(i_y_req),
    .i_y_source_pointer_reg(i_y_source_pointer_reg), .i_dma_req(i_dma_req),
    .i_dma_we(i_dma_we), .o_x_rdata(o_x_rdata), .o_x_rvalid(o_x_rvalid),
    .o_y_rvalid(o_y_rvalid), .o_addr_trap(o_addr_trap),
    .o_special_register_we(o_special_register_we),
    .o_special_register_lane(o_special_register_lane), .o_dma_rvalid(o_dma_rvalid));

/* tb/dsau_dma_model.sv */
// Purpose: dma controller stand-in on the dma ram port
// Assumes: one request per go pulse
// Notes: idle lines toggle so a stale value never passes
`timescale 1ns/1ps
module dsau_dma_model (
    input wire i_clk_sys,
    input wire i_go,
    input wire i_we,
    input wire [9:0] i_addr,
    input wire [15:0] i_wdata,
    output logic o_req = 1'b0,
    output logic o_we = 1'b0,
    output logic [9:0] o_addr = 10'h000,
    output logic [15:0] o_wdata = 16'h0000
);
    // silent unless told, so the ram also serves as plain storage
    always @(posedge i_clk_sys) begin
        o_req <= i_go;
        o_we <= i_go & i_we;
        o_addr <= i_go ? i_addr : ~o_addr;
        o_wdata <= i_go ? i_wdata : ~o_wdata;
    end
endmodule // dsau_dma_model

/* tb/dsau_top_tb.sv */
// Purpose: self-checking bench for the data space access unit
// Assumes: answers land within three cycles of the taking edge
// Notes: dma traffic comes through dsau_dma_model
`timescale 1ns/1ps
module dsau_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, x_req = 1'b0, x_we = 1'b0, x_byte = 1'b0;
    logic x_near = 1'b0, y_req = 1'b0, y_mod = 1'b0, dma_go = 1'b0, sfr_hit = 1'b0;
    logic [1:0] x_mode = 2'h0, x_wid = 2'h0;
    logic [3:0] x_sel = 4'h0, g_sel;
    logic [15:0] x_ptr = 16'h0000, x_wd = 16'h0000, y_ptr = 16'h0000;
    logic x_rv, y_rv, trap, sfr_we, wreg_we, dma_rv, tr, dma_req, dma_we;
    logic [3:0] wreg_sel;
    logic [9:0] dma_addr;
    logic [15:0] x_rd, y_rd, x_np, wreg_d, dma_rdata, dma_wdata, g_rd, g_y, g_np, g_wreg, g_dma;
    logic dgo = 1'b0, dwe = 1'b0, hit_v = 1'b0, near_v = 1'b0, y_en = 1'b0;
    logic [1:0] wid_v = 2'h0;
    logic [9:0] dma_a = 10'h005;
    logic [15:0] dma_d = 16'hC0DE;
    logic [3:0] sel_v = 4'h0;
    int fail_count = 0, n_checks = 0, cycles = 0;
    logic [33:0] rows [0:11] = '{34'h2_0900_1234, 34'h3_0901_00AB, 34'h2_0902_5555,
        34'h2_1800_7E01, 34'h3_0041_00CD, 34'h0_0900_AB34, 34'h1_0901_00AB, 34'h1_0900_0034,
        34'h0_8000_0000, 34'h0_0100_0000, 34'h0_2A00_0000, 34'h0_1800_7E01};
    dsau_dma_model dsau_dma_model_inst (.i_clk_sys(clk), .i_go(dma_go), .i_we(dwe),
        .i_addr(dma_a), .i_wdata(dma_d), .o_req(dma_req), .o_we(dma_we),
        .o_addr(dma_addr), .o_wdata(dma_wdata));
    dsau_top dsau_top_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_x_req(x_req), .i_x_we(x_we),
        .i_x_byte(x_byte), .i_x_near(x_near), .i_x_mode(x_mode), .i_x_source_pointer_reg(x_ptr),
        .i_x_modulo_start(16'h0980), .i_x_modulo_end(16'h0A00), .i_x_wdata(x_wd),
        .i_x_wreg_sel(x_sel), .i_x_widen(x_wid), .i_y_req(y_req), .i_y_modulo(y_mod),
        .i_y_source_pointer_reg(y_ptr), .i_y_modulo_start(16'h1800),
        .i_y_modulo_end(16'h2000), .i_dma_req(dma_req), .i_dma_we(dma_we),
        .i_dma_addr(dma_addr), .i_dma_wdata(dma_wdata), .i_special_register_rdata(16'hA5A5),
        .i_special_register_hit(sfr_hit), .o_x_rdata(x_rd), .o_x_rvalid(x_rv),
        .o_y_rdata(y_rd), .o_y_rvalid(y_rv), .o_x_next_pointer(x_np), .o_y_next_pointer(),
        .o_addr_trap(trap), .o_special_register_we(sfr_we), .o_special_register_lane(),
        .o_special_register_addr(), .o_special_register_wdata(), .o_wreg_data(wreg_d),
        .o_wreg_we(wreg_we), .o_wreg_sel(wreg_sel), .o_dma_rdata(dma_rdata),
        .o_dma_rvalid(dma_rv));
    always #10 clk = ~clk;
    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // r holds write, byte, pointer and data; the extra edge lines up dma traffic
    task automatic acc(input logic [33:0] r, input logic [1:0] md);
        @(posedge clk);
        dma_go <= dgo;
        sfr_hit <= hit_v;
        @(posedge clk);
        dma_go <= 1'b0;
        {x_we, x_byte, x_ptr, x_wd} <= r;
        {x_req, x_mode, x_near, x_sel, x_wid} <= {1'b1, md, near_v, sel_v, wid_v};
        {y_req, y_mod, y_ptr} <= {y_en, y_en, 16'h1800};
        @(posedge clk);
        {x_req, y_req} <= 2'h0;
        {x_ptr, x_wd} <= ~r[31:0];
        {g_rd, g_y, g_np, g_wreg, g_dma} = {5{16'hXXXX}};
        tr = 1'b0;
        // the pointer answer stands only in the cycle after the taking edge
        @(negedge clk);
        g_np = x_np;
        repeat (3) begin
            @(negedge clk);
            if (x_rv === 1'b1) g_rd = x_rd;
            if (y_rv === 1'b1) g_y = y_rd;
            if (wreg_we === 1'b1) {g_sel, g_wreg} = {wreg_sel, wreg_d};
            if (dma_rv === 1'b1) g_dma = dma_rdata;
            if (trap === 1'b1) tr = 1'b1;
        end
    endtask
    initial begin
        repeat (9) @(posedge clk);
        @(negedge clk);
        chk({x_rv, y_rv, trap, sfr_we, wreg_we, dma_rv, 10'h000}, 16'h0000);
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            acc(rows[i], 2'h0);
            if (!rows[i][33]) chk(g_rd, rows[i][15:0]);
        end
        hit_v = 1'b1;
        acc(34'h0_0102_0000, 2'h0);
        chk(g_rd, 16'hA5A5);
        hit_v = 1'b0;
        sel_v = 4'h3;
        acc(34'h1_0901_0000, 2'h1);
        chk({g_sel, 4'h0, g_wreg[7:0]}, 16'h30AB);
        chk(g_np, 16'h0902);
        acc(34'h0_0900_0000, 2'h1);
        chk(g_np, 16'h0902);
        for (int k = 1; k < 3; k++) begin
            wid_v = k[1:0];
            acc(34'h1_0901_0000, 2'h0);
            chk(g_wreg, (k == 1) ? 16'hFFAB : 16'h00AB);
        end
        wid_v = 2'h0;
        acc(34'h0_0A00_0000, 2'h2);
        chk(g_np, 16'h0980);
        near_v = 1'b1;
        acc(34'h0_6900_0000, 2'h0);
        chk(g_rd, 16'hAB34);
        near_v = 1'b0;
        acc(34'h2_0903_FFFF, 2'h0);
        chk({15'h0000, tr}, 16'h0001);
        acc(34'h0_0902_0000, 2'h0);
        chk(g_rd, 16'h5555);
        acc(34'h0_0905_0000, 2'h0);
        chk({15'h0000, tr}, 16'h0001);
        y_en = 1'b1;
        acc(34'h0_0900_0000, 2'h0);
        chk(g_y, 16'h7E01);
        chk(g_rd, 16'hAB34);
        {y_en, dgo, dwe} = 3'h7;
        acc(34'h2_200A_BEEF, 2'h0);
        dwe = 1'b0;
        acc(34'h0_200A_0000, 2'h0);
        chk(g_rd, 16'hBEEF);
        chk(g_dma, 16'hBEEF);
        {dma_a, dwe} = {10'h006, 1'b1};
        acc(34'h2_200E_1357, 2'h0);
        dwe = 1'b0;
        acc(34'h0_200E_0000, 2'h0);
        chk(g_rd, 16'h1357);
        chk(g_dma, 16'hC0DE);
        finish_test();
    end
endmodule // dsau_top_tb
